/* logic/fcg_pkg.sv */
// Constants for the global configuration and bus watchdog block.
// Assumes a single 40 MHz system clock.
package fcg_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ          = 40_000_000;
  // Register offset and field positions
  localparam logic [7:0]  GLOBAL_CONTROL_OFS = 8'h00;
  localparam int unsigned BIT_STANDBY     = 7;
  localparam int unsigned BIT_SOFT_RESET  = 6;
  localparam int unsigned BIT_BUS_TO_DIS  = 5;
  localparam int unsigned BIT_FAIL_ALL_DIS = 4;
  localparam int unsigned BIT_TIMING_SRC  = 3;
  localparam int unsigned WD_SEL_LSB      = 1;
  // Value after reset, watchdog field filled from the strap
  localparam logic [7:0]  GLOBAL_CONTROL_POR = 8'h00;
  localparam logic [1:0]  WD_SEL_OFF      = 2'h0;
  localparam logic [1:0]  WD_SEL_2S       = 2'h1;
  localparam logic [1:0]  WD_SEL_6S       = 2'h2;
  localparam logic [1:0]  WD_SEL_10S      = 2'h3;
  // Times in their own units and derived cycle counts
  localparam int unsigned BUS_TIMEOUT_MS  = 35;
  localparam int unsigned BUS_TIMEOUT_CYC = (CLK_HZ / 1000) * BUS_TIMEOUT_MS;
  localparam int unsigned WD_2S_S         = 2;
  localparam int unsigned WD_6S_S         = 6;
  localparam int unsigned WD_10S_S        = 10;
  localparam int unsigned WD_2S_CYC       = CLK_HZ * WD_2S_S;
  localparam int unsigned WD_6S_CYC       = CLK_HZ * WD_6S_S;
  localparam int unsigned WD_10S_CYC      = CLK_HZ * WD_10S_S;
  // Drive width and full scale
  localparam int unsigned FAN_COUNT       = 4;
  localparam int unsigned DRIVE_W         = 9;
  localparam logic [8:0]  DRIVE_FULL      = 9'h1ff;
endpackage

/* logic/fcg_global_ctrl.sv */
// Global configuration register, bus-stuck timeout, fan fail-all and I2C watchdog.
// Assumes an I2C front end that decodes register accesses and flags each valid transaction.
//
// How it works
// RL1: Writing one to bit 6 of global_control returns every register to its power-on value.
// RL2: The soft reset bit clears itself and always reads back as zero.
// RL3: With bit 5 clear, SDA low longer than 35 ms resets the I2C interface; bit 5 set disables it.
// RL4: With bit 4 clear, any fan failure drives every other fan to full scale; bit 4 set suppresses it.
// RL5: Bit 3 picks the timing source, zero the internal oscillator, one the external crystal.
// RL6: After the crystal is picked, the internal oscillator stays in use until the crystal has started.
// RL7: A crystal that never starts leaves the device on the internal oscillator for good.
// RL8: Bits 2:1 set the watchdog period 00 off, 01 2 s, 10 6 s, 11 10 s, reset value from the strap pin.
// RL9: An active watchdog with no valid transaction in its period drives all fans to full scale.
// RL10: Once valid transactions resume, fans return to their programmed drive and programming is accepted.
// RL11: The bus master must address the device regularly while the watchdog is active.
// RL12: Bit 7 selects run or standby on run_o; fan_drive_o is not gated by it and keeps updating in standby.
`timescale 1ns/1ps
module fcg_global_ctrl #(
  parameter int unsigned FANS        = fcg_pkg::FAN_COUNT,
  parameter int unsigned BUS_TO_CYC  = fcg_pkg::BUS_TIMEOUT_CYC,
  parameter int unsigned WD_2_CYC    = fcg_pkg::WD_2S_CYC,
  parameter int unsigned WD_6_CYC    = fcg_pkg::WD_6S_CYC,
  parameter int unsigned WD_10_CYC   = fcg_pkg::WD_10S_CYC
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Strap
  input  wire logic                 watchdog_default_pin_i,
  // Register access from the I2C front end
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic      [7:0]           reg_rdata_o,
  // Bus activity
  input  wire logic                 xact_valid_i,
  input  wire logic                 sda_i,
  output logic                      i2c_reset_o,
  // Fan path
  input  wire logic [FANS-1:0]      fan_fail_i,
  input  wire logic [FANS*9-1:0]    drive_req_i,
  output logic      [FANS*9-1:0]    fan_drive_o,
  output logic                      prog_enable_o,
  output logic                      run_o,
  output logic                      soft_reset_o,
  // Timing source
  input  wire logic                 crystal_ready_i,
  output logic                      clk_src_xtal_o
);
  import fcg_pkg::*;

  logic [7:0]  global_control;
  logic [31:0] sda_low_cnt;
  logic [31:0] wd_cnt;
  logic [31:0] wd_limit;
  logic        wd_timed_out;
  logic        next_timed_out;
  logic        ctrl_wr;
  logic        soft_wr;
  logic [1:0]  wd_sel;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == GLOBAL_CONTROL_OFS);
  assign soft_wr = ctrl_wr && reg_wdata_i[BIT_SOFT_RESET];
  assign wd_sel  = global_control[WD_SEL_LSB +: 2];

  // Control register; strap taken on the synchronous reset or a soft reset
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_wr) begin // RL1
      global_control <= GLOBAL_CONTROL_POR;
      global_control[WD_SEL_LSB +: 2] <= watchdog_default_pin_i ? WD_SEL_10S : WD_SEL_OFF; // RL8
    end else if (ctrl_wr) begin
      global_control <= reg_wdata_i;
      global_control[BIT_SOFT_RESET] <= 1'b0; // RL2
    end
  end

  // Soft reset pulse to the rest of the device, one cycle long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= soft_wr; // RL1
    end
  end

  // Read data; unmapped addresses return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= (reg_addr_i == GLOBAL_CONTROL_OFS) ? (global_control & 8'hbf) : 8'h00; // RL2
    end
  end

  // Run or standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o <= 1'b1;
    end else begin
      run_o <= ~global_control[BIT_STANDBY]; // RL12
    end
  end

  // Timing source; a dead crystal simply never raises its ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_src_xtal_o <= 1'b0;
    end else begin
      clk_src_xtal_o <= global_control[BIT_TIMING_SRC] && crystal_ready_i; // RL5 RL6 RL7
    end
  end

  // SDA stuck-low counter, saturates so the reset fires once per stuck episode
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_wr || sda_i || global_control[BIT_BUS_TO_DIS]) begin // RL3
      sda_low_cnt <= 32'h0;
      i2c_reset_o <= 1'b0;
    end else begin
      i2c_reset_o <= (sda_low_cnt == 32'(BUS_TO_CYC) - 32'h1); // RL3
      if (sda_low_cnt != 32'(BUS_TO_CYC)) begin
        sda_low_cnt <= sda_low_cnt + 32'h1;
      end
    end
  end

  // Watchdog period select
  always_comb begin
    unique case (wd_sel)
      WD_SEL_OFF: wd_limit = 32'h0;
      WD_SEL_2S:  wd_limit = 32'(WD_2_CYC);
      WD_SEL_6S:  wd_limit = 32'(WD_6_CYC);
      WD_SEL_10S: wd_limit = 32'(WD_10_CYC);
    endcase
  end

  // Timeout state: any valid transaction ends it
  always_comb begin
    next_timed_out = wd_timed_out;
    if (xact_valid_i || (wd_sel == WD_SEL_OFF)) begin
      next_timed_out = 1'b0; // RL10
    end else if (wd_cnt == wd_limit - 32'h1) begin
      next_timed_out = 1'b1; // RL9
    end
  end

  // Watchdog counter, restarted by every valid transaction
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_wr || xact_valid_i || (wd_sel == WD_SEL_OFF)) begin
      wd_cnt <= 32'h0;
    end else if (wd_cnt < wd_limit) begin // Never runs past a shortened period
      wd_cnt <= wd_cnt + 32'h1;
    end
  end

  // Timeout flag and programming gate; outside registers freeze so the old drive returns
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_wr) begin
      wd_timed_out  <= 1'b0;
      prog_enable_o <= 1'b1;
    end else begin
      wd_timed_out  <= next_timed_out;
      prog_enable_o <= ~next_timed_out; // RL10
    end
  end

  // Per-channel drive: full scale on watchdog timeout or another fan's failure
  for (genvar i = 0; i < FANS; i++) begin : g_fan
    logic others_failed;
    assign others_failed = |(fan_fail_i & ~(FANS'(1) << i));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        fan_drive_o[i*DRIVE_W +: DRIVE_W] <= '0;
      end else if (wd_timed_out || (others_failed && !global_control[BIT_FAIL_ALL_DIS])) begin // RL4 RL9
        fan_drive_o[i*DRIVE_W +: DRIVE_W] <= DRIVE_FULL;
      end else begin
        fan_drive_o[i*DRIVE_W +: DRIVE_W] <= drive_req_i[i*DRIVE_W +: DRIVE_W]; // RL10
      end
    end
  end

  // Checks
  sequence seq_soft_wr;
    reg_wr_i && (reg_addr_i == GLOBAL_CONTROL_OFS) && reg_wdata_i[BIT_SOFT_RESET];
  endsequence
  sequence seq_soft_done;
    soft_reset_o && (global_control[7:3] == 5'h00) ##1 (!soft_reset_o || $past(soft_wr));
  endsequence

  AST_SOFT_RESET: assert property (@(posedge clk_i) disable iff (rst_i) seq_soft_wr |=> seq_soft_done) // RL1
    else $error("soft reset did not restore control register");
  AST_SOFT_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) !reg_rdata_o[BIT_SOFT_RESET]) // RL2
    else $error("soft reset bit read back as one");
  AST_BUS_TO_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(global_control[BIT_BUS_TO_DIS]) |-> !i2c_reset_o) // RL3
    else $error("bus timeout fired while disabled");
  AST_BUS_TO_NEED_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    i2c_reset_o |-> $past(!sda_i) && $past(sda_low_cnt) == 32'(BUS_TO_CYC) - 32'h1) // RL3
    else $error("bus timeout fired without sda held low");
  AST_FAIL_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_fail_i[0] && !global_control[BIT_FAIL_ALL_DIS]) |=> fan_drive_o[DRIVE_W*2-1 -: DRIVE_W] == DRIVE_FULL) // RL4
    else $error("fail-all did not drive other fan to full scale");
  AST_OSC_INTERNAL: assert property (@(posedge clk_i) disable iff (rst_i)
    !global_control[BIT_TIMING_SRC] |=> !clk_src_xtal_o) // RL5
    else $error("crystal used while internal oscillator selected");
  AST_XTAL_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    !crystal_ready_i [*2] |-> !clk_src_xtal_o) // RL6 RL7
    else $error("switched to crystal before it started");
  AST_WD_STRAP: assert property (@(posedge clk_i)
    ($past(rst_i) || $past(soft_wr)) && !rst_i
    |-> wd_sel == ($past(watchdog_default_pin_i) ? WD_SEL_10S : WD_SEL_OFF)) // RL8
    else $error("watchdog reset value does not follow strap");
  AST_WD_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_timed_out |=> fan_drive_o == {FANS{DRIVE_FULL}}) // RL9
    else $error("watchdog timeout did not drive fans full");
  AST_WD_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
    (wd_timed_out && xact_valid_i) |=> !wd_timed_out && prog_enable_o) // RL10
    else $error("valid transaction did not end watchdog timeout");
  AST_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(global_control[BIT_STANDBY]) |=> !run_o) // RL12
    else $error("standby not reflected on run output");
endmodule // fcg_global_ctrl

/* sim/fcg_host_model.sv */
// Stand-in for the I2C front end: decoded register strobes plus a transaction flag.
// Assumes the bench clock; drives only on its falling edge.
`timescale 1ns/1ps
module fcg_host_model (
  // Clock
  input  wire logic       clk_i,
  // Strobes toward the device
  output logic            wr_o,
  output logic            rd_o,
  output logic            xact_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  // Idle bus at time zero
  initial {wr_o, rd_o, xact_o, addr_o, wdata_o} = 19'h0;

  // Every access also flags a valid transaction, which keeps the watchdog fed
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, rd_o, xact_o, addr_o, wdata_o} = {w, !w, 1'b1, a, d};
    @(negedge clk_i);
    {wr_o, rd_o, xact_o} = 3'h0;
    addr_o = ~a; // Released lines never show the old value
    wdata_o = ~d;
  endtask
endmodule // fcg_host_model

/* sim/fcg_global_ctrl_tb.sv */
// Self-checking bench for the global control block with an integer model.
// Assumes the host model above; long counts shortened by parameters.
`timescale 1ns/1ps
module fcg_global_ctrl_tb;
  import fcg_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        strap = 1;
  logic        sda = 1;
  logic        xtal_rdy = 0;
  logic [3:0]  fail = 4'h0;
  logic [35:0] req = 36'h0;
  logic [35:0] fan;
  logic [7:0]  rdata, addr, wdata;
  logic        wr, rd, xact, i2c_rst, prog_en, run, srst, xsrc;
  int          n_fail = 0;
  int          check_count = 0;
  int          mreg, pulses, pos, lim;

  // Free-running 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  fcg_host_model host_u (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .xact_o(xact), .addr_o(addr), .wdata_o(wdata));
  fcg_global_ctrl #(.BUS_TO_CYC(8), .WD_2_CYC(20), .WD_6_CYC(40), .WD_10_CYC(60)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .watchdog_default_pin_i(strap), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .xact_valid_i(xact), .sda_i(sda),
    .i2c_reset_o(i2c_rst), .fan_fail_i(fail), .drive_req_i(req), .fan_drive_o(fan),
    .prog_enable_o(prog_en), .run_o(run), .soft_reset_o(srst), .crystal_ready_i(xtal_rdy),
    .clk_src_xtal_o(xsrc));

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic tend(input string t);
    $display("test %s done, fails %0d", t, n_fail);
  endtask
  // Model follows every write; soft reset reloads the strap value
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_u.acc(1'b1, a, d);
    if (a == 8'h00) mreg = d[6] ? (strap ? 6 : 0) : d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    host_u.acc(1'b0, a, 8'h00);
    chk("rdata", (a == 8'h00) ? (mreg & 8'hbf) : 0, rdata);
  endtask
  // A fan goes full if the watchdog expired or another fan failed
  function automatic logic [35:0] exp_fan(input logic wd_out);
    logic [35:0] e;
    e = req;
    for (int i = 0; i < 4; i++)
      if (wd_out || (!mreg[4] && (fail & ~(4'h1 << i)) != 0)) e[9*i +: 9] = DRIVE_FULL;
    return e;
  endfunction
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(56));
    req[31:0] = $urandom;
    req[35:32] = 4'($urandom);
    cyc(16);
    rst_i = 0;
    mreg = 6;
    rd_chk(8'h00);
    chk("run", 1, run);
    tend("reset");
    // Random settings, watchdog kept off, crystal not ready
    for (int i = 0; i < 6; i++) begin
      wr_reg(8'h00, (8'($urandom) & 8'hb9) | ((i == 0) ? 8'h08 : 8'h00));
      rd_chk(8'h00);
      chk("run", !mreg[7], run);
      chk("xsrc", 0, xsrc);
    end
    xtal_rdy = 1;
    wr_reg(8'h00, 8'h08);
    cyc(1);
    chk("xsrc", 1, xsrc);
    xtal_rdy = 0;
    cyc(2);
    chk("xsrc", 0, xsrc);
    wr_reg(8'h07, 8'hff);
    rd_chk(8'h07);
    rd_chk(8'h00);
    wr_reg(8'h00, 8'h7f);
    chk("srst", 1, srst);
    cyc(1);
    chk("srst", 0, srst);
    rd_chk(8'h00);
    tend("regs");
    // Stuck SDA, timeout enabled then disabled
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h00, k ? 8'h20 : 8'h00);
      pulses = 0;
      pos = 0;
      sda = 0;
      for (int c = 1; c <= 20; c++) begin
        @(negedge clk_i);
        if (i2c_rst === 1'b1) begin
          pulses++;
          pos = c;
        end
      end
      sda = 1;
      chk("i2c_pulses", k ? 0 : 1, pulses);
      if (k == 0) chk("i2c_pos", 8, pos);
    end
    tend("bus_timeout");
    // Fan failure, fail-all enabled then suppressed
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h00, k ? 8'h10 : 8'h00);
      fail = 4'($urandom) | (k ? 4'h2 : 4'h1);
      cyc(2);
      chk("fan", exp_fan(0), fan);
      fail = 4'h0;
      cyc(2);
      chk("fan", exp_fan(0), fan);
    end
    tend("fail_all");
    // Every watchdog period: expire, then recover on a transaction
    for (int s = 1; s < 4; s++) begin
      lim = 20 * s;
      wr_reg(8'h00, 8'(s << 1));
      cyc(lim - 1);
      chk("prog", 1, prog_en);
      chk("fan", exp_fan(0), fan);
      cyc(1);
      chk("prog", 0, prog_en);
      chk("fan", exp_fan(0), fan);
      cyc(1);
      chk("fan", exp_fan(1), fan);
      rd_chk(8'h00);
      cyc(1);
      chk("prog", 1, prog_en);
      chk("fan", exp_fan(0), fan);
    end
    tend("watchdog");
    // Second reset with the strap low, then a soft reset that re-reads it
    strap = 0;
    rst_i = 1;
    cyc(2);
    rst_i = 0;
    mreg = 0;
    rd_chk(8'h00);
    wr_reg(8'h00, 8'h46);
    rd_chk(8'h00);
    tend("strap_low");
    end_sim();
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    cyc(5000);
    n_fail++;
    end_sim();
  end
endmodule // fcg_global_ctrl_tb
